// *** lie_regs.sv ***
// Purpose: Register front end and error handling of a LIN controller
// Assumes: Bus strobes are one-cycle pulses synchronous to sys_clk_i
// Notes:   Read data appears on the cycle after the read strobe
// Operation
// - Error abandons frame and raises interrupt.
// - Error reset write clears causes and flag.
// - No master start or wake-up during error.
// - Pointer is 8-bit read/write, resets zero.
// - Data port read returns pointed core register.
// - Data port write stores into pointed register.
// - Config bit 7 enables controller, reset zero.
// - Config bit 6 selects master, reset one.
// - Config bit 5 selects auto baud, slave only.
// - Config bits 4..0 read zero, ignore writes.
// - Fifteen core registers at indices 0x00..0x0E.
// - Mode-specific bits accessible only in that mode.
// - Eight data bytes, read/write, reset zero.
// - Error reset bit reads zero; zero ignored.
// - Start request self-clears on done or error.
module lie_regs
   import lie_pkg::*;
#(
   parameter int DATA_BYTES = lie_pkg::LIE_DATA_BYTES,
   parameter int FIFO_DEPTH = lie_pkg::LIE_FIFO_DEPTH
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [7:0]        sfr_addr_i,
   input  wire logic              sfr_wr_i,
   input  wire logic              sfr_rd_i,
   input  wire logic [7:0]        sfr_wdata_i,
   output logic      [7:0]        sfr_rdata_o,
   input  wire lie_pkg::lie_evt_s evt_i,
   input  wire logic              rx_valid_i,
   input  wire logic [7:0]        rx_data_i,
   output logic                   rx_ready_o,
   output lie_pkg::lie_cfg_s      cfg_o,
   output lie_pkg::lie_cmd_s      cmd_o,
   output logic                   irq_o
);
   import lie_pkg::*;

   // Mask of bits visible in the current mode for a core register
   function automatic logic [7:0] mode_mask(input logic [7:0] idx, input logic master);
      logic [7:0] m;
      m = 8'h_FF;
      if (idx == LIE_IDX_CONTROL) begin
         m = master ? ~LIE_CTL_SLAVE_MASK : ~LIE_CTL_MASTER_MASK;
      end else if (idx == LIE_IDX_STATUS) begin
         m = master ? ~LIE_ST_SLAVE_MASK : 8'h_FF;
      end else if (idx == LIE_IDX_ERROR) begin
         m = master ? (LIE_ERR_USED_MASK & ~LIE_ERR_SLAVE_MASK) : LIE_ERR_USED_MASK;
      end
      return m;
   endfunction

   // Frame data byte index check
   function automatic logic is_data_idx(input logic [7:0] idx);
      return idx <= LIE_IDX_DATA_LAST;
   endfunction

   logic [7:0] cfg_reg;
   logic [7:0] pointer_reg;
   logic [7:0] data_reg [DATA_BYTES];
   logic       sleep_reg;
   logic       txrx_reg;
   logic       start_reg;
   logic       wake_reg;
   logic       int_reg;
   logic       error_reg;
   logic       done_reg;
   logic       idle_reg;
   logic       abort_reg;
   logic       wakeup_reg;
   logic [4:0] cause_reg;
   logic [7:0] size_reg;
   logic [7:0] div_reg;
   logic [7:0] mul_reg;
   logic [7:0] id_reg;
   logic [2:0] rx_idx_reg;
   logic       is_master;
   logic       core_wr;
   logic [7:0] core_wdata;
   logic [7:0] status_view;
   logic [7:0] control_view;
   logic [7:0] core_rdata;
   logic       wr_ctl;
   logic       drain_valid;
   logic       drain_ready;
   logic [7:0] drain_data;

   assign is_master = cfg_reg[LIE_CFG_MASTER];
   // Data port writes reach only defined indices, with mode bits masked
   assign core_wr    = sfr_wr_i && (sfr_addr_i == LIE_ADDR_DATA)
                       && (pointer_reg <= LIE_IDX_IDENT);
   assign core_wdata = sfr_wdata_i & mode_mask(pointer_reg, is_master);
   assign wr_ctl     = core_wr && (pointer_reg == LIE_IDX_CONTROL);
   // Received bytes wait in the FIFO while the CPU writes the data port
   assign drain_ready = !(sfr_wr_i && (sfr_addr_i == LIE_ADDR_DATA));

   lie_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (rx_valid_i),
      .in_data_i   (rx_data_i),
      .in_ready_o  (rx_ready_o),
      .out_valid_o (drain_valid),
      .out_ready_i (drain_ready),
      .out_data_o  (drain_data)
   );

   // Direct configuration register; unused low bits never store
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= LIE_CFG_RESET;
      end else if (sfr_wr_i && sfr_addr_i == LIE_ADDR_CONFIG) begin
         cfg_reg <= sfr_wdata_i & LIE_CFG_USED_MASK;
      end
   end

   // Indirect pointer; data port traffic leaves it alone
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pointer_reg <= LIE_ZERO_BYTE;
      end else if (sfr_wr_i && sfr_addr_i == LIE_ADDR_POINTER) begin
         pointer_reg <= sfr_wdata_i;
      end
   end

   // Receive write index restarts at each new frame
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_idx_reg <= '0;
      end else if (cmd_o.start_frame || cmd_o.data_ack) begin
         rx_idx_reg <= '0;
      end else if (drain_valid && drain_ready) begin
         rx_idx_reg <= rx_idx_reg + 1'b1;
      end
   end

   // Frame data bytes: CPU write has priority, FIFO drain stalls meanwhile
   for (genvar i = 0; i < DATA_BYTES; i++) begin : g_data
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            data_reg[i] <= LIE_ZERO_BYTE;
         end else if (core_wr && pointer_reg == 8'(i)) begin
            data_reg[i] <= sfr_wdata_i;
         end else if (drain_valid && drain_ready && rx_idx_reg == 3'(i)) begin
            data_reg[i] <= drain_data;
         end
      end
   end

   // Plain read/write core registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         size_reg <= LIE_ZERO_BYTE;
         div_reg  <= LIE_ZERO_BYTE;
         mul_reg  <= LIE_ZERO_BYTE;
         id_reg   <= LIE_ZERO_BYTE;
      end else if (core_wr) begin
         if (pointer_reg == LIE_IDX_SIZE)    size_reg <= core_wdata;
         if (pointer_reg == LIE_IDX_DIVIDER) div_reg  <= core_wdata;
         if (pointer_reg == LIE_IDX_MULT)    mul_reg  <= core_wdata;
         if (pointer_reg == LIE_IDX_IDENT)   id_reg   <= core_wdata & LIE_ID_USED_MASK;
      end
   end

   // Stored control bits; sleep is slave-only through the write mask
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sleep_reg <= 1'b0;
         txrx_reg  <= 1'b0;
      end else if (wr_ctl) begin
         sleep_reg <= core_wdata[LIE_CTL_SLEEP];
         txrx_reg  <= core_wdata[LIE_CTL_TXRX];
      end
   end

   // Start request: refused during error, cleared by done or error
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_reg <= 1'b0;
      end else if (evt_i.err_event || evt_i.frame_done) begin
         start_reg <= 1'b0;
      end else if (wr_ctl && core_wdata[LIE_CTL_START] && !error_reg
                   && cfg_reg[LIE_CFG_ENABLE]) begin
         start_reg <= 1'b1;
      end
   end

   // Wake-up request in either mode, also blocked by the error flag
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_reg <= 1'b0;
      end else if (evt_i.err_event || evt_i.frame_done) begin
         wake_reg <= 1'b0;
      end else if (wr_ctl && core_wdata[LIE_CTL_WAKE] && !error_reg
                   && cfg_reg[LIE_CFG_ENABLE]) begin
         wake_reg <= 1'b1;
      end
   end

   // Error flag and causes; a new error outranks a same-cycle reset write
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         error_reg <= 1'b0;
         cause_reg <= '0;
      end else if (evt_i.err_event) begin
         error_reg <= 1'b1;
         cause_reg <= (wr_ctl && core_wdata[LIE_CTL_ERROR_RESET_BIT])
                      ? evt_i.err_cause : cause_reg | evt_i.err_cause;
      end else if (wr_ctl && core_wdata[LIE_CTL_ERROR_RESET_BIT]) begin
         error_reg <= 1'b0;
         cause_reg <= '0;
      end
   end

   // Interrupt and sticky status events; reset-interrupt write clears them
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_reg    <= 1'b0;
         done_reg   <= 1'b0;
         idle_reg   <= 1'b0;
         abort_reg  <= 1'b0;
         wakeup_reg <= 1'b0;
      end else begin
         if (evt_i.err_event || evt_i.frame_done || evt_i.idle_timeout
             || evt_i.wake_detect || evt_i.data_request) begin
            int_reg <= 1'b1;
         end else if (wr_ctl && core_wdata[LIE_CTL_RSTINT]) begin
            int_reg <= 1'b0;
         end
         if (evt_i.frame_done || evt_i.wake_detect) begin
            done_reg <= 1'b1;
         end else if (wr_ctl && core_wdata[LIE_CTL_RSTINT]) begin
            done_reg <= 1'b0;
         end
         if (evt_i.idle_timeout) begin
            idle_reg <= 1'b1;
         end else if (wr_ctl && core_wdata[LIE_CTL_RSTINT]) begin
            idle_reg <= 1'b0;
         end
         if (evt_i.abort) begin
            abort_reg <= 1'b1;
         end else if (wr_ctl && core_wdata[LIE_CTL_RSTINT]) begin
            abort_reg <= 1'b0;
         end
         if (evt_i.wake_detect) begin
            wakeup_reg <= 1'b1;
         end else if (wr_ctl && core_wdata[LIE_CTL_RSTINT]) begin
            wakeup_reg <= 1'b0;
         end
      end
   end

   // Register views; write-only bits always read back as zero
   always_comb begin
      control_view = LIE_ZERO_BYTE;
      control_view[LIE_CTL_SLEEP] = sleep_reg;
      control_view[LIE_CTL_TXRX]  = txrx_reg;
      control_view[LIE_CTL_WAKE]  = wake_reg;
      control_view[LIE_CTL_START] = start_reg;
      status_view = LIE_ZERO_BYTE;
      status_view[LIE_ST_ACTIVE] = evt_i.bus_active;
      status_view[LIE_ST_IDLE]   = idle_reg;
      status_view[LIE_ST_ABORT]  = abort_reg;
      status_view[LIE_ST_DTREQ]  = evt_i.data_request;
      status_view[LIE_ST_INT]    = int_reg;
      status_view[LIE_ST_ERROR]  = error_reg;
      status_view[LIE_ST_WAKEUP] = wakeup_reg;
      status_view[LIE_ST_DONE]   = done_reg;
   end

   // Indirect read selection over the fifteen core registers
   always_comb begin
      case (pointer_reg)
         LIE_IDX_CONTROL: core_rdata = control_view;
         LIE_IDX_STATUS:  core_rdata = status_view;
         LIE_IDX_ERROR:   core_rdata = {3'b000, cause_reg};
         LIE_IDX_SIZE:    core_rdata = size_reg;
         LIE_IDX_DIVIDER: core_rdata = div_reg;
         LIE_IDX_MULT:    core_rdata = mul_reg;
         LIE_IDX_IDENT:   core_rdata = id_reg;
         default: begin
            if (is_data_idx(pointer_reg)) begin
               core_rdata = data_reg[pointer_reg[2:0]];
            end else begin
               core_rdata = LIE_ZERO_BYTE;
            end
         end
      endcase
   end

   // Registered read data, zero for unmapped addresses
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= LIE_ZERO_BYTE;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            LIE_ADDR_CONFIG:  sfr_rdata_o <= cfg_reg;
            LIE_ADDR_POINTER: sfr_rdata_o <= pointer_reg;
            LIE_ADDR_DATA:
               sfr_rdata_o <= core_rdata & mode_mask(pointer_reg, is_master);
            default:          sfr_rdata_o <= LIE_ZERO_BYTE;
         endcase
      end
   end

   // One-cycle commands; start and wake pulse on acceptance only
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_o <= '0;
      end else begin
         cmd_o.start_frame   <= wr_ctl && core_wdata[LIE_CTL_START] && !error_reg
                                && cfg_reg[LIE_CFG_ENABLE] && !evt_i.err_event;
         cmd_o.send_wakeup   <= wr_ctl && core_wdata[LIE_CTL_WAKE] && !error_reg
                                && cfg_reg[LIE_CFG_ENABLE] && !evt_i.err_event;
         cmd_o.data_ack      <= wr_ctl && core_wdata[LIE_CTL_DTACK];
         cmd_o.stop_comm     <= wr_ctl && core_wdata[LIE_CTL_STOP];
         cmd_o.abandon_frame <= evt_i.err_event;
      end
   end

   // Configuration toward the frame engine; auto baud only counts in slave mode
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_o <= '0;
         irq_o <= 1'b0;
      end else begin
         cfg_o.enable          <= cfg_reg[LIE_CFG_ENABLE];
         cfg_o.master          <= cfg_reg[LIE_CFG_MASTER];
         cfg_o.auto_baud       <= cfg_reg[LIE_CFG_AUTOBAUD] && !is_master;
         cfg_o.txrx            <= txrx_reg;
         cfg_o.sleep           <= sleep_reg;
         cfg_o.length_checksum <= size_reg;
         cfg_o.divider         <= div_reg;
         cfg_o.multiplier      <= mul_reg;
         cfg_o.identifier      <= id_reg;
         irq_o                 <= int_reg || evt_i.err_event;
      end
   end
endmodule // lie_regs

// *** lie_pkg.sv ***
// Purpose: Shared constants and carriers of the LIN register front end
// Assumes: 8-bit special function register bus, one system clock
// Notes:   Core registers are reached indirectly through pointer and data port
package lie_pkg;

   // Direct register addresses on the special function register bus
   localparam logic [7:0] LIE_ADDR_CONFIG  = 8'h_C9;
   localparam logic [7:0] LIE_ADDR_DATA    = 8'h_D2;
   localparam logic [7:0] LIE_ADDR_POINTER = 8'h_D3;

   // Indirect core register indices
   localparam logic [7:0] LIE_IDX_DATA_LAST = 8'h_07;
   localparam logic [7:0] LIE_IDX_CONTROL   = 8'h_08;
   localparam logic [7:0] LIE_IDX_STATUS    = 8'h_09;
   localparam logic [7:0] LIE_IDX_ERROR     = 8'h_0A;
   localparam logic [7:0] LIE_IDX_SIZE      = 8'h_0B;
   localparam logic [7:0] LIE_IDX_DIVIDER   = 8'h_0C;
   localparam logic [7:0] LIE_IDX_MULT      = 8'h_0D;
   localparam logic [7:0] LIE_IDX_IDENT     = 8'h_0E;

   // Configuration register fields and reset value
   localparam int         LIE_CFG_ENABLE    = 7;
   localparam int         LIE_CFG_MASTER    = 6;
   localparam int         LIE_CFG_AUTOBAUD  = 5;
   localparam logic [7:0] LIE_CFG_RESET     = 8'h_60;
   localparam logic [7:0] LIE_CFG_USED_MASK = 8'h_E0;

   // Frame control fields
   localparam int LIE_CTL_STOP   = 7;
   localparam int LIE_CTL_SLEEP  = 6;
   localparam int LIE_CTL_TXRX   = 5;
   localparam int LIE_CTL_DTACK  = 4;
   localparam int LIE_CTL_RSTINT = 3;
   localparam int LIE_CTL_ERROR_RESET_BIT = 2;
   localparam int LIE_CTL_WAKE   = 1;
   localparam int LIE_CTL_START  = 0;

   // Frame status fields
   localparam int LIE_ST_ACTIVE = 7;
   localparam int LIE_ST_IDLE   = 6;
   localparam int LIE_ST_ABORT  = 5;
   localparam int LIE_ST_DTREQ  = 4;
   localparam int LIE_ST_INT    = 3;
   localparam int LIE_ST_ERROR  = 2;
   localparam int LIE_ST_WAKEUP = 1;
   localparam int LIE_ST_DONE   = 0;

   // Mode-restricted bit masks per core register
   localparam logic [7:0] LIE_CTL_SLAVE_MASK  = 8'h_D0;
   localparam logic [7:0] LIE_CTL_MASTER_MASK = 8'h_01;
   localparam logic [7:0] LIE_ST_SLAVE_MASK   = 8'h_30;
   localparam logic [7:0] LIE_ERR_SLAVE_MASK  = 8'h_18;
   localparam logic [7:0] LIE_ERR_USED_MASK   = 8'h_1F;
   localparam logic [7:0] LIE_ID_USED_MASK    = 8'h_3F;
   localparam logic [7:0] LIE_ZERO_BYTE       = 8'h_00;

   // Frame data buffer geometry
   localparam int LIE_DATA_BYTES = 8;
   localparam int LIE_FIFO_DEPTH = 8;

   // Events reported by the frame engine
   typedef struct packed {
      logic       err_event;   // Any protocol error, one-cycle pulse
      logic [4:0] err_cause;   // Synch, parity, timeout, checksum, bit mismatch
      logic       frame_done;  // Transfer or wake-up completed, pulse
      logic       idle_timeout;
      logic       abort;
      logic       wake_detect;
      logic       bus_active;  // Level
      logic       data_request;// Level
   } lie_evt_s;

   // Configuration that steers the frame engine
   typedef struct packed {
      logic       enable;
      logic       master;
      logic       auto_baud;
      logic       txrx;
      logic       sleep;
      logic [7:0] length_checksum;
      logic [7:0] divider;
      logic [7:0] multiplier;
      logic [7:0] identifier;
   } lie_cfg_s;

   // One-cycle commands toward the frame engine
   typedef struct packed {
      logic start_frame;
      logic send_wakeup;
      logic data_ack;
      logic stop_comm;
      logic abandon_frame;
   } lie_cmd_s;

endpackage

// *** lie_fifo.sv ***
// Purpose: Receive byte FIFO between frame engine and data buffer
// Assumes: Single clock; push and pop may happen in the same cycle
// Notes:   Full and empty are registered so that ready and valid are flops
module lie_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_valid_o && out_ready_i;
   assign out_data_o = mem_reg[rd_ptr_reg];

   // Occupancy after this cycle's push and pop
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Pointers and registered full and empty flags
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         count_reg   <= '0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         count_reg   <= count_next;
         in_ready_o  <= (count_next != (AW+1)'(DEPTH));
         out_valid_o <= (count_next != '0);
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge sys_clk_i) begin
      if (push) mem_reg[wr_ptr_reg] <= in_data_i;
   end
endmodule // lie_fifo

// *** lie_regs_checker.sv ***
// Purpose: Port-level checks of the LIN register front end
// Assumes: One clock; bound onto every lie_regs
// Notes:   Pointer and error flag are shadowed from bus traffic and error events
module lie_regs_checker
   import lie_pkg::*;
(
   input wire logic              sys_clk_i,
   input wire logic              rst_n_i,
   input wire logic [7:0]        sfr_addr_i,
   input wire logic              sfr_wr_i,
   input wire logic              sfr_rd_i,
   input wire logic [7:0]        sfr_wdata_i,
   input wire logic [7:0]        sfr_rdata_o,
   input wire lie_pkg::lie_evt_s evt_i,
   input wire lie_pkg::lie_cfg_s cfg_o,
   input wire lie_pkg::lie_cmd_s cmd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ptr_reg;
   logic       err_reg;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Shadow state; a new error wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_reg <= 8'h_00;
         err_reg <= 1'b0;
      end else begin
         if (sfr_wr_i && sfr_addr_i == LIE_ADDR_POINTER) ptr_reg <= sfr_wdata_i;
         if (evt_i.err_event) err_reg <= 1'b1;
         else if (sfr_wr_i && sfr_addr_i == LIE_ADDR_DATA && ptr_reg == LIE_IDX_CONTROL
                  && sfr_wdata_i[LIE_CTL_ERROR_RESET_BIT]) err_reg <= 1'b0;
      end
   end
   AST_ERR_ABANDON: assert property (evt_i.err_event |=> cmd_o.abandon_frame)
      else $error("no abandon after error");
   AST_NO_START: assert property ($past(err_reg) |-> !cmd_o.start_frame)
      else $error("start during error");
   AST_NO_WAKE: assert property ($past(err_reg) |-> !cmd_o.send_wakeup)
      else $error("wakeup during error");
   AST_RDATA_HOLD: assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
      else $error("read data moved");
   AST_CFG_LOW: assert property (sfr_rd_i && sfr_addr_i == LIE_ADDR_CONFIG
      |=> sfr_rdata_o[4:0] == 5'h_00) else $error("config low bits set");
   AST_PTR_FAR: assert property (sfr_rd_i && sfr_addr_i == LIE_ADDR_DATA
      && ptr_reg > LIE_IDX_IDENT |=> sfr_rdata_o == LIE_ZERO_BYTE) else $error("far read");
   AST_AUTOBAUD: assert property (cfg_o.auto_baud |-> !cfg_o.master)
      else $error("auto baud in master mode");
   AST_START_PULSE: assert property (cmd_o.start_frame |=> !cmd_o.start_frame)
      else $error("start held");
   cover property (cmd_o.start_frame);
   cover property (cmd_o.send_wakeup);
   cover property (cmd_o.abandon_frame);
endmodule // lie_regs_checker

bind lie_regs lie_regs_checker i_lie_regs_checker (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o), .evt_i(evt_i), .cfg_o(cfg_o), .cmd_o(cmd_o));

// *** lie_engine_model.sv ***
// Purpose: Behavioural frame engine facing the register front end
// Assumes: Bench commands errors and byte fills
// Notes:   Finishes each frame one cycle after its start command
module lie_engine_model
   import lie_pkg::*;
(
   input wire logic              sys_clk_i,
   input wire logic              rst_n_i,
   input wire logic              err_go_i,
   input wire logic [4:0]        cause_i,
   input wire logic              fill_i,
   input wire logic              rx_ready_i,
   input wire lie_pkg::lie_cmd_s cmd_i,
   output lie_pkg::lie_evt_s     evt_o,
   output logic                  rx_valid_o,
   output logic [7:0]            rx_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] nb_reg;
   logic [7:0] nb_next;
   logic       more;
   // A byte stands until taken; released lines show its inverse
   assign nb_next = nb_reg + {7'h_00, rx_valid_o & rx_ready_i};
   assign more = fill_i && nb_next < 8'h_49;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_o <= '0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 8'h_00;
         nb_reg <= 8'h_41;
      end else begin
         evt_o.err_event <= err_go_i;
         evt_o.err_cause <= err_go_i ? cause_i : 5'h_1F; // Junk outside an error
         evt_o.frame_done <= cmd_i.start_frame | cmd_i.send_wakeup;
         nb_reg <= nb_next;
         rx_valid_o <= more;
         rx_data_o <= more ? nb_next : ~nb_next;
      end
   end
endmodule // lie_engine_model

// *** tb_lin_indirect_regs_error_ctl.sv ***
// Purpose: Register-level tests of the LIN front end
// Assumes: Inputs change on the falling edge
// Notes:   Read data is sampled two falling edges after the strobe
module tb_lin_indirect_regs_error_ctl;
   import lie_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk_i, rst_n_i, wr, rd, err_go, fill, rx_valid, rx_ready, irq;
   logic [7:0] addr, wdata, rdata, rx_data;
   logic [4:0] cause;
   lie_evt_s   evt;
   lie_cmd_s   cmd;
   lie_cfg_s   cfg;
   int         err_total, checks;
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   lie_regs i_lie_regs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .evt_i(evt),
      .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready), .cfg_o(cfg),
      .cmd_o(cmd), .irq_o(irq));
   lie_engine_model i_lie_engine_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .err_go_i(err_go), .cause_i(cause), .fill_i(fill), .rx_ready_i(rx_ready),
      .cmd_i(cmd), .evt_o(evt), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge sys_clk_i);
      wr = 1'b0;
   endtask
   task automatic rd_b(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk_i);
      rd = 1'b0;
      @(negedge sys_clk_i);
      chk(rdata, exp);
   endtask
   task automatic iw(input logic [7:0] i, input logic [7:0] d);
      wr_b(LIE_ADDR_POINTER, i);
      wr_b(LIE_ADDR_DATA, d);
   endtask
   task automatic ir(input logic [7:0] i, input logic [7:0] exp);
      wr_b(LIE_ADDR_POINTER, i);
      rd_b(LIE_ADDR_DATA, exp);
   endtask
   // One-cycle error from the engine side; the model adds a stage, so wait it out
   task automatic err(input logic [4:0] c);
      @(negedge sys_clk_i);
      err_go = 1'b1;
      cause = c;
      @(negedge sys_clk_i);
      err_go = 1'b0;
      @(negedge sys_clk_i);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {rst_n_i, wr, rd, err_go, fill, addr, wdata, cause} = '0;
      err_total = 0;
      checks = 0;
      repeat (8) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      rd_b(LIE_ADDR_CONFIG, LIE_CFG_RESET);
      rd_b(LIE_ADDR_POINTER, 8'h_00);
      chk({cfg.enable, cfg.master, cfg.auto_baud, 5'h_00}, 8'h_40);
      for (int i = 0; i < 8; i++) ir(8'(i), 8'h_00);
      wr_b(LIE_ADDR_CONFIG, 8'h_FF);
      rd_b(LIE_ADDR_CONFIG, 8'h_E0);
      rd_b(8'h_00, 8'h_00);
      wr_b(LIE_ADDR_CONFIG, 8'h_C0);
      for (int i = 0; i < 8; i++) iw(8'(i), 8'h_A0 + 8'(i));
      for (int i = 0; i < 8; i++) ir(8'(i), 8'h_A0 + 8'(i));
      rd_b(LIE_ADDR_DATA, 8'h_A7);
      rd_b(LIE_ADDR_POINTER, 8'h_07);
      iw(LIE_IDX_IDENT, 8'h_FF);
      ir(LIE_IDX_IDENT, 8'h_3F);
      iw(8'h_0F, 8'h_55);
      ir(8'h_0F, 8'h_00);
      $display("end of register map test");
      // Wake-up, then a master frame that also rewinds the receive index
      for (int k = 0; k < 2; k++) begin
         iw(LIE_IDX_CONTROL, k ? 8'h_01 : 8'h_02);
         ir(LIE_IDX_STATUS, 8'h_09);
         ir(LIE_IDX_CONTROL, 8'h_00);
         chk({7'h_00, irq}, 8'h_01);
         iw(LIE_IDX_CONTROL, 8'h_08);
      end
      fill = 1'b1;
      // Let the first byte be offered before waiting for the burst to end
      @(negedge sys_clk_i);
      for (int k = 0; k < 60 && rx_valid !== 1'b0; k++) @(negedge sys_clk_i);
      chk({6'h_00, rx_valid, rx_ready}, 8'h_01);
      repeat (4) @(negedge sys_clk_i);
      for (int i = 0; i < 8; i++) ir(8'(i), 8'h_41 + 8'(i));
      $display("end of frame test");
      err(5'h_04);
      chk({7'h_00, irq}, 8'h_01);
      ir(LIE_IDX_ERROR, 8'h_04);
      for (int k = 0; k < 2; k++) begin
         iw(LIE_IDX_CONTROL, k ? 8'h_02 : 8'h_01);
         ir(LIE_IDX_STATUS, 8'h_0C);
      end
      iw(LIE_IDX_CONTROL, 8'h_0C);
      ir(LIE_IDX_ERROR, 8'h_00);
      ir(LIE_IDX_STATUS, 8'h_00);
      ir(LIE_IDX_CONTROL, 8'h_00);
      chk({7'h_00, irq}, 8'h_00);
      $display("end of error test");
      wr_b(LIE_ADDR_CONFIG, 8'h_A0);
      iw(LIE_IDX_CONTROL, 8'h_01);
      ir(LIE_IDX_STATUS, 8'h_00);
      chk({cfg.enable, cfg.master, cfg.auto_baud, 5'h_00}, 8'h_A0);
      err(5'h_1F);
      ir(LIE_IDX_ERROR, 8'h_1F);
      wr_b(LIE_ADDR_CONFIG, 8'h_C0);
      ir(LIE_IDX_ERROR, 8'h_07);
      $display("end of mode test");
      summarize();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      err_total++;
      summarize();
   end
endmodule // tb_lin_indirect_regs_error_ctl
